/* smb_cfg.svh */
`ifndef SMB_CFG_SVH
`define SMB_CFG_SVH
`define ADDR_W 29
`define DATA_W 32
`define GAP_MAX 2'h1
`endif

/* smb_pkg.sv */
`include "smb_cfg.svh"
package smb_pkg;
    typedef logic [`ADDR_W-1:0] addr_t;
    typedef logic [`DATA_W-1:0] data_t;
    typedef enum logic [2:0] {
        S_IDLE, S_REQ, S_OWN, S_GAP, S_DROP_ABE, S_DROP_WAIT
    } arb_e;
endpackage : smb_pkg

/* smb_bus_if.sv */
`timescale 1ns/1ps
interface smb_bus_if;
    // shared address, data, direction, size
    logic [28:0] addrOut;
    logic addrOe;
    logic [31:0] dataOut;
    logic dataOe;
    logic [31:0] dataIn;
    logic readNotWriteOut;
    logic byteNotWordOut;
    logic ctlOe;
    // arbitration and host control
    logic memReqN;
    logic procReqN;
    logic dataBusEnable;
    logic hostBusEnable;
    logic hostStallN;
    logic lockCycle;
    logic hostInternal;
    // open drain interrupts
    logic irqOe;
    logic fiqOe;
    modport second_end (
        output addrOut, addrOe, dataOut, dataOe, readNotWriteOut,
        output byteNotWordOut, ctlOe, procReqN, hostBusEnable,
        output hostStallN, irqOe, fiqOe,
        input dataIn, memReqN, dataBusEnable, lockCycle, hostInternal
    );
    modport host_end (
        output memReqN, lockCycle, hostInternal,
        input procReqN, hostBusEnable, hostStallN, dataBusEnable,
        input addrOut, addrOe
    );
endinterface : smb_bus_if

/* host_card_end.sv */
`timescale 1ns/1ps
module host_card_end (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clkEn,
    // host core side
    input wire logic wantBus,
    input wire logic internalNext,
    input wire logic swapActive,
    output logic frozen,
    output logic tristated,
    // bus
    smb_bus_if.host_end bus
);
    import smb_pkg::*;
    typedef struct packed {
        logic memReqN;
        logic lockCycle;
        logic hostInternal;
        logic frozen;
        logic tristated;
    } st_s;
    st_s cur_ff;
    st_s nxt_cur;
    // host holds its cycle while stalled (see [RULE6] [RULE11])
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.frozen = !bus.hostStallN;
        nxt_cur.tristated = !bus.hostBusEnable || !bus.dataBusEnable;
        if (bus.hostStallN) begin
            nxt_cur.memReqN = !wantBus; // see [RULE6]
            nxt_cur.lockCycle = swapActive; // see [RULE11]
            nxt_cur.hostInternal = internalNext;
        end
    end
    // reset from the system line (see [RULE17] [RULE18])
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cur_ff <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        end else if (clkEn) begin
            cur_ff <= nxt_cur;
        end
    end
    assign bus.memReqN = cur_ff.memReqN;
    assign bus.lockCycle = cur_ff.lockCycle;
    assign bus.hostInternal = cur_ff.hostInternal;
    assign frozen = cur_ff.frozen;
    assign tristated = cur_ff.tristated;
endmodule : host_card_end

/* second_master_end.sv */
`timescale 1ns/1ps
`include "smb_cfg.svh"
// Notes on behaviour
// [RULE1] bus owner drives the address bus
// [RULE2] never use the top address line; the code passes bit 28 of xferAddr to addrOut
// [RULE3] data released during direct memory access
// [RULE4] direction low read, high write
// [RULE5] size low byte, high word
// [RULE6] host pulls memory request for next cycle
// [RULE7] drive request low to want bus
// [RULE8] release data while data enable low
// [RULE9] pull host bus enable low when owning
// [RULE10] hold host stall low while active
// [RULE11] host raises lock during atomic swap
// [RULE12] normal interrupt open drain, low only
// [RULE13] fast interrupt open drain, low only
// [RULE14] readable interrupt flag register
// [RULE15] interrupt mask register gates sources
// [RULE16] works with no reference clock
// [RULE17] reset from the system reset line
// [RULE18] memory clock times all bus activity
// [RULE19] arbitrate clock high, drive on falling edge
// [RULE20] request only before host internal, not swap
// [RULE21] drop request, then enable, then stall
// [RULE22] one-cycle gap keeps bus, longer loses
// [RULE23] idle: pins released, controls inactive
module second_master_end #(
    parameter int ADDR_W = `ADDR_W,
    parameter int DATA_W = `DATA_W
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clkEn,
    // user transfer request
    input wire logic xferReq,
    input wire logic xferWrite,
    input wire logic xferByte,
    input wire smb_pkg::addr_t xferAddr,
    input wire smb_pkg::data_t xferData,
    output logic xferDone,
    output smb_pkg::data_t rdData,
    output logic owning,
    // interrupt sources and registers
    input wire logic [1:0] irqSrc,
    input wire logic [1:0] maskWrData,
    input wire logic maskWr,
    input wire logic [1:0] flagClr,
    output logic [1:0] irqFlags,
    output logic [1:0] irqMask,
    // bus
    smb_bus_if.second_end bus
);
    import smb_pkg::*;
    initial begin
        if (ADDR_W != `ADDR_W || DATA_W != `DATA_W) begin
            $error("unsupported width");
        end
    end
    typedef struct packed {
        arb_e st;
        logic gap;
        logic settle;
        addr_t addr;
        data_t data;
        logic rnw;
        logic bnw;
        logic drv;
        logic wrData;
        logic reqN;
        logic abe;
        logic stallN;
        logic done;
        data_t rd;
        logic [1:0] flags;
        logic [1:0] mask;
        logic [1:0] srcSync1;
        logic [1:0] srcSync2;
        logic [1:0] memSync1;
        logic [1:0] memSync2;
        logic irqOe;
        logic fiqOe;
    } st_s;
    st_s cur_ff;
    st_s nxt_cur;
    st_s out_ff;
    logic hostInt;
    logic lockS;
    logic dbeS;
    // synchronised host status; memSync2 = {internal, lock}
    assign hostInt = cur_ff.memSync2[1];
    assign lockS = cur_ff.memSync2[0];
    assign dbeS = bus.dataBusEnable;
    // arbitration while clock high, i.e. on the rising edge (see [RULE19])
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.done = 1'b0;
        nxt_cur.memSync1 = {bus.hostInternal, bus.lockCycle};
        nxt_cur.memSync2 = cur_ff.memSync1;
        nxt_cur.srcSync1 = irqSrc;
        nxt_cur.srcSync2 = cur_ff.srcSync1;
        case (cur_ff.st)
            S_IDLE: begin
                // only ahead of a host internal, never inside a swap
                if (xferReq && hostInt && !lockS) begin // see [RULE20]
                    nxt_cur.reqN = 1'b0; // see [RULE7]
                    nxt_cur.st = S_REQ;
                end
            end
            S_REQ: begin
                nxt_cur.abe = 1'b0; // see [RULE9]
                nxt_cur.stallN = 1'b0; // see [RULE10]
                nxt_cur.addr = xferAddr; // see [RULE2]
                nxt_cur.data = xferData;
                nxt_cur.rnw = xferWrite; // see [RULE4]
                nxt_cur.bnw = !xferByte; // see [RULE5]
                nxt_cur.wrData = xferWrite;
                nxt_cur.drv = 1'b1; // see [RULE1]
                nxt_cur.settle = 1'b1;
                nxt_cur.st = S_OWN;
            end
            // unit on the pins completes, then one cycle lets the
            // user present the next unit before it is latched
            S_OWN: begin
                if (cur_ff.settle) begin
                    if (!cur_ff.rnw) begin
                        nxt_cur.rd = bus.dataIn;
                    end
                    nxt_cur.done = 1'b1;
                    nxt_cur.settle = 1'b0;
                end else if (cur_ff.done) begin
                    nxt_cur.settle = 1'b0;
                end else if (xferReq) begin
                    nxt_cur.addr = xferAddr;
                    nxt_cur.data = xferData;
                    nxt_cur.rnw = xferWrite;
                    nxt_cur.bnw = !xferByte;
                    nxt_cur.wrData = xferWrite;
                    nxt_cur.settle = 1'b1;
                end else begin
                    nxt_cur.reqN = 1'b1; // see [RULE21]
                    nxt_cur.gap = 1'b0;
                    nxt_cur.st = S_GAP;
                end
            end
            S_GAP: begin
                // a single-cycle gap keeps ownership
                if (xferReq && !cur_ff.gap) begin // see [RULE22]
                    nxt_cur.reqN = 1'b0;
                    nxt_cur.st = S_OWN;
                end else begin
                    nxt_cur.drv = 1'b0;
                    nxt_cur.abe = 1'b1; // see [RULE21]
                    nxt_cur.st = S_DROP_WAIT;
                end
            end
            S_DROP_WAIT: begin
                nxt_cur.stallN = 1'b1; // see [RULE21]
                nxt_cur.st = S_IDLE;
            end
            default: nxt_cur.st = S_IDLE;
        endcase
        // flags: set wins over clear (see [RULE14])
        nxt_cur.flags = (cur_ff.flags & ~flagClr) | cur_ff.srcSync2;
        if (maskWr) begin
            nxt_cur.mask = maskWrData; // see [RULE15]
        end
        nxt_cur.irqOe = cur_ff.flags[0] & cur_ff.mask[0]; // see [RULE12]
        nxt_cur.fiqOe = cur_ff.flags[1] & cur_ff.mask[1]; // see [RULE13]
    end
    // state on memory clock, system reset (see [RULE17] [RULE18])
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cur_ff <= '0;
            cur_ff.st <= S_IDLE;
            cur_ff.reqN <= 1'b1; // see [RULE23]
            cur_ff.abe <= 1'b1;
            cur_ff.stallN <= 1'b1;
        end else if (clkEn) begin
            cur_ff <= nxt_cur;
        end
    end
    // pins relaunched from falling edge (see [RULE19]); no reference clock
    always_ff @(negedge sys_clk or negedge rstn) begin // see [RULE16]
        if (!rstn) begin
            out_ff <= '0;
            out_ff.reqN <= 1'b1;
            out_ff.abe <= 1'b1;
            out_ff.stallN <= 1'b1;
        end else if (clkEn) begin
            out_ff <= cur_ff;
        end
    end
    // pins released unless owning (see [RULE23])
    assign bus.addrOut = out_ff.addr;
    assign bus.addrOe = out_ff.drv;
    assign bus.ctlOe = out_ff.drv;
    assign bus.readNotWriteOut = out_ff.rnw;
    assign bus.byteNotWordOut = out_ff.bnw;
    assign bus.dataOut = out_ff.data;
    // data off while dma enable low (see [RULE3] [RULE8])
    assign bus.dataOe = out_ff.drv & out_ff.wrData & dbeS;
    assign bus.procReqN = out_ff.reqN;
    assign bus.hostBusEnable = out_ff.abe;
    assign bus.hostStallN = out_ff.stallN;
    assign bus.irqOe = out_ff.irqOe;
    assign bus.fiqOe = out_ff.fiqOe;
    assign xferDone = cur_ff.done;
    assign rdData = cur_ff.rd;
    assign owning = cur_ff.drv;
    assign irqFlags = cur_ff.flags;
    assign irqMask = cur_ff.mask;
endmodule : second_master_end

/* smb_chk.sv */
`timescale 1ns/1ps
module smb_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // arbitration pins
    input wire logic procReqN,
    input wire logic hostBusEnable,
    input wire logic hostStallN,
    input wire logic dataBusEnable,
    // drive enables
    input wire logic addrOe,
    input wire logic dataOe,
    input wire logic ctlOe
);
    // one domain, so one clock and reset for all
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // pins released while the host owns the bus
    a_idle_pins_off: assert property (
        hostBusEnable |-> !addrOe && !ctlOe && !dataOe)
        else $error("drive while not owning");
    // dbe gates dataOe directly without a register, yet allow one cycle
    a_dma_data_off: assert property (
        !dataBusEnable [*2] |-> !dataOe)
        else $error("data driven during dma");
    a_stall_covers_own: assert property (
        !hostBusEnable |-> !hostStallN)
        else $error("host not stalled");
    a_abe_after_req: assert property (
        $rose(hostBusEnable) |-> $past(procReqN) && !hostStallN ##1 hostStallN)
        else $error("release order");
    a_stall_after_abe: assert property (
        $rose(hostStallN) |-> hostBusEnable && $past(hostBusEnable))
        else $error("stall released early");
    a_req_then_own: assert property (
        $fell(procReqN) |=> !hostBusEnable)
        else $error("no ownership after request");
    a_own_drives_addr: assert property (
        $fell(hostBusEnable) |-> addrOe && ctlOe)
        else $error("owner not driving");
    // a gap longer than one cycle must give the bus back
    a_gap_bounded: assert property (
        procReqN && !hostBusEnable |=> hostBusEnable || !procReqN)
        else $error("gap kept bus");
endmodule : smb_chk

/* tb.sv */
`timescale 1ns/1ps
module tb;
    import smb_pkg::*;
    // stimulus and observed signals
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic swapActive = 1'b0;
    logic xferReq = 1'b0;
    logic xferWrite = 1'b0;
    logic xferByte = 1'b0;
    addr_t xferAddr = 29'h0;
    data_t xferData = 32'h0;
    logic [1:0] irqSrc = 2'h0;
    logic [1:0] maskWrData = 2'h0;
    logic maskWr = 1'b0;
    logic [1:0] flagClr = 2'h0;
    logic xferDone;
    data_t rdData;
    logic [1:0] irqFlags;
    logic [1:0] irqMask;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    smb_bus_if bus ();
    // host never competes, so only the second end arbitrates
    host_card_end host_card_end_i (.sys_clk(sys_clk), .rstn(rstn),
        .clkEn(1'b1), .wantBus(1'b0), .internalNext(1'b1),
        .swapActive(swapActive), .frozen(), .tristated(), .bus(bus));
    second_master_end second_master_end_i (.sys_clk(sys_clk), .rstn(rstn),
        .clkEn(1'b1), .xferReq(xferReq), .xferWrite(xferWrite),
        .xferByte(xferByte), .xferAddr(xferAddr), .xferData(xferData),
        .xferDone(xferDone), .rdData(rdData), .owning(),
        .irqSrc(irqSrc), .maskWrData(maskWrData), .maskWr(maskWr),
        .flagClr(flagClr), .irqFlags(irqFlags), .irqMask(irqMask),
        .bus(bus));
    smb_chk smb_chk_i (.sys_clk(sys_clk), .rstn(rstn),
        .procReqN(bus.procReqN), .hostBusEnable(bus.hostBusEnable),
        .hostStallN(bus.hostStallN), .dataBusEnable(bus.dataBusEnable),
        .addrOe(bus.addrOe), .dataOe(bus.dataOe), .ctlOe(bus.ctlOe));
    // clock
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    // bound the run in case a handshake never completes
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            summarize();
        end
    end
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : check
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    // burst of n units; lk holds a swap lock over the first cycles
    task automatic xfer(input logic wr, input logic byt, input addr_t a,
                        input int n, input logic lk);
        int w;
        addr_t ak;
        swapActive <= lk;
        // a swap is under way before the request, as on a real host
        if (lk) begin
            repeat (4) @(posedge sys_clk);
        end
        xferReq <= 1'b1;
        xferWrite <= wr;
        xferByte <= byt;
        xferAddr <= a;
        xferData <= {3'h0, ~a};
        if (lk) begin
            repeat (10) @(posedge sys_clk);
            check(bus.procReqN, 1'b1);
            swapActive <= 1'b0;
        end
        for (int k = 0; k < n; k++) begin
            ak = addr_t'(a + k);
            w = 0;
            do begin
                @(posedge sys_clk);
                w++;
            end while (xferDone !== 1'b1 && w < 40);
            check({bus.addrOut, bus.readNotWriteOut}, {ak, wr});
            check({bus.byteNotWordOut, bus.addrOe}, {~byt, 1'b1});
            check(bus.dataOe, wr & bus.dataBusEnable);
            check(wr ? bus.dataOut : rdData,
                  wr ? {3'h0, ~ak} : 32'hA5C30F96);
            xferAddr <= addr_t'(ak + 1);
            xferData <= {3'h0, ~addr_t'(ak + 1)};
            if (k == n - 1) begin
                xferReq <= 1'b0;
            end
        end
        repeat (5) @(posedge sys_clk);
        check({bus.procReqN, bus.hostBusEnable, bus.hostStallN}, 3'h7);
    endtask : xfer
    // main sequence
    initial begin
        bus.dataIn = 32'hA5C30F96;
        bus.dataBusEnable = 1'b1;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        check({bus.procReqN, bus.hostBusEnable, bus.hostStallN, bus.addrOe}, 4'hE);
        xfer(1'b1, 1'b0, 29'h1FFFFFF0, 1, 1'b1);
        xfer(1'b0, 1'b1, 29'h00000100, 3, 1'b0);
        bus.dataBusEnable <= 1'b0;
        xfer(1'b1, 1'b0, 29'h00000200, 1, 1'b0);
        bus.dataBusEnable <= 1'b1;
        irqSrc <= 2'h3;
        repeat (5) @(posedge sys_clk);
        check(irqFlags, 2'h3);
        maskWr <= 1'b1;
        maskWrData <= 2'h2;
        irqSrc <= 2'h0;
        @(posedge sys_clk);
        maskWr <= 1'b0;
        repeat (4) @(posedge sys_clk);
        // fast source unmasked, normal source masked
        check({irqMask, irqFlags, bus.irqOe, bus.fiqOe}, 6'h2D);
        flagClr <= 2'h3;
        @(posedge sys_clk);
        flagClr <= 2'h0;
        repeat (3) @(posedge sys_clk);
        check({irqMask, irqFlags, bus.irqOe, bus.fiqOe}, 6'h20);
        summarize();
    end
endmodule : tb
